// ===== hdl/i2crec_params.svh
// Purpose: Constants for the I2C target serial engine with bus recovery.
// Assumes: Included by the top-level design file and the bench by bare name.
// Notes: Address and command codes are plain defaults of this block.
`ifndef I2CREC_PARAMS_SVH
`define I2CREC_PARAMS_SVH
`define I2CREC_GENCALL_ADDR 7'h00
`define I2CREC_DEV_ADDR 7'h2C
`define I2CREC_CMD_WRITE 2'h0
`define I2CREC_CMD_INC 2'h1
`define I2CREC_CMD_DEC 2'h2
`define I2CREC_CMD_READ 2'h3
`define I2CREC_WIPER_MID 9'h080
`define I2CREC_WIPER_FULL 9'h100
`define I2CREC_WIPER_ZERO 9'h000
`define I2CREC_NUM_WIPERS 4
`define I2CREC_BITS_PER_BYTE 4'h8
`endif

// ===== hdl/i2crec_pkg.sv
// Purpose: Types shared by the I2C target serial engine.
// Assumes: Nothing beyond the constants header.
// Notes: States of the serial engine.
package i2crec_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_CMD,
        ST_DATA,
        ST_TX,
        ST_RXACK
    } i2crec_state_t;
endpackage

// ===== hdl/i2crec_edge.sv
// Purpose: Line sampler that flags SCL rising and falling edges and Start/Stop.
// Assumes: Inputs are synchronous to the system clock.
// Notes: One instance watches both bus lines.
`timescale 1ns/100ps
module i2crec_edge (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_rise_out,
    output logic scl_fall_out,
    output logic start_out,
    output logic stop_out
);
    logic scl_q;
    logic sda_q;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end
    assign scl_rise_out = scl_in & ~scl_q;
    assign scl_fall_out = ~scl_in & scl_q;
    assign start_out = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_out = scl_in & scl_q & ~sda_q & sda_in;
endmodule

// ===== hdl/i2crec_top.sv
// Purpose: I2C target serial engine with software reset recovery and general call.
// Assumes: SCL and SDA are synchronous to CLK_SYS_IN; SDA is open drain.
// Notes: Frame is address, command byte (wiper index and opcode), data byte.
`timescale 1ns/100ps
`include "i2crec_params.svh"
module i2crec_top #(
    parameter logic [6:0] DEV_ADDR = `I2CREC_DEV_ADDR
) (
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    output logic [8:0] WIPER0_OUT,
    output logic [8:0] WIPER1_OUT,
    output logic [8:0] WIPER2_OUT,
    output logic [8:0] WIPER3_OUT,
    output logic BUSY_OUT
);
    logic rst_s1;
    logic rstn;
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rst_s1 <= 1'b0;
            rstn <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rstn <= rst_s1;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    i2crec_edge u_edge (
        .clk_in(CLK_SYS_IN),
        .rstn_in(rstn),
        .scl_in(SCL_IN),
        .sda_in(SDA_IN),
        .scl_rise_out(scl_rise),
        .scl_fall_out(scl_fall),
        .start_out(start_det),
        .stop_out(stop_det)
    );

    i2crec_pkg::i2crec_state_t state;
    i2crec_pkg::i2crec_state_t ret_state;
    localparam i2crec_pkg::i2crec_state_t ST_IDLE = i2crec_pkg::ST_IDLE;
    localparam i2crec_pkg::i2crec_state_t ST_ADDR = i2crec_pkg::ST_ADDR;
    localparam i2crec_pkg::i2crec_state_t ST_ACK = i2crec_pkg::ST_ACK;
    localparam i2crec_pkg::i2crec_state_t ST_CMD = i2crec_pkg::ST_CMD;
    localparam i2crec_pkg::i2crec_state_t ST_DATA = i2crec_pkg::ST_DATA;
    localparam i2crec_pkg::i2crec_state_t ST_TX = i2crec_pkg::ST_TX;
    localparam i2crec_pkg::i2crec_state_t ST_RXACK = i2crec_pkg::ST_RXACK;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rd_mode;
    logic gencall;
    logic ack_ok;
    logic phase_cmd;
    logic [1:0] widx;
    logic [1:0] opc;
    logic wr_pend;
    logic [8:0] wr_val;
    logic [8:0] wiper [`I2CREC_NUM_WIPERS];

    wire byte_done = scl_rise && (bit_cnt == `I2CREC_BITS_PER_BYTE - 4'h1);
    wire [7:0] rx_byte = {shreg[6:0], SDA_IN};
    wire addr_hit = (rx_byte[7:1] == DEV_ADDR);
    wire gc_hit = (rx_byte[7:1] == `I2CREC_GENCALL_ADDR) && !rx_byte[0];
    wire [8:0] cur_w = wiper[widx];
    wire can_inc = cur_w < `I2CREC_WIPER_FULL;
    wire can_dec = (cur_w != `I2CREC_WIPER_ZERO) && (cur_w <= `I2CREC_WIPER_FULL);
    // Increment and decrement step right after the command acknowledge.
    // In the ack slot bit_cnt is 1 between the opening and the closing SCL fall.
    wire ack_end = (state == ST_ACK) && scl_fall && (bit_cnt == 4'h1);
    wire step_now = ack_end && phase_cmd && ack_ok;
    wire do_inc = step_now && (opc == `I2CREC_CMD_INC) && can_inc;
    wire do_dec = step_now && (opc == `I2CREC_CMD_DEC) && can_dec;
    // The engine is blind to Start while it holds the line low.
    wire line_held = SDA_OE_OUT && !SDA_OUT;
    wire start_seen = start_det && !line_held;

    always_ff @(posedge CLK_SYS_IN or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            ret_state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rd_mode <= 1'b0;
            gencall <= 1'b0;
            ack_ok <= 1'b0;
            phase_cmd <= 1'b0;
            widx <= 2'h0;
            opc <= 2'h0;
            wr_pend <= 1'b0;
            wr_val <= 9'h000;
            SDA_OUT <= 1'b1;
            SDA_OE_OUT <= 1'b0;
        end else if (start_seen) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            wr_pend <= 1'b0;
            SDA_OE_OUT <= 1'b0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            wr_pend <= 1'b0;
            SDA_OE_OUT <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    SDA_OE_OUT <= 1'b0;
                end
                ST_ADDR, ST_CMD, ST_DATA: begin
                    if (scl_rise) begin
                        shreg <= rx_byte;
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        bit_cnt <= 4'h0;
                        phase_cmd <= (state == ST_CMD);
                        if (state == ST_ADDR) begin
                            ack_ok <= addr_hit || gc_hit;
                            gencall <= gc_hit;
                            rd_mode <= rx_byte[0] && addr_hit;
                            ret_state <= ST_CMD;
                        end else if (state == ST_CMD) begin
                            widx <= rx_byte[3:2];
                            opc <= rx_byte[1:0];
                            ack_ok <= !(gencall && rx_byte[1:0] == `I2CREC_CMD_READ);
                            ret_state <= ST_DATA;
                        end else begin
                            // A write is armed and commits only on Stop.
                            wr_pend <= 1'b1;
                            wr_val <= {opc[0], rx_byte};
                            ack_ok <= 1'b1;
                            ret_state <= ST_DATA;
                        end
                        state <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (scl_fall && bit_cnt == 4'h0) begin
                        // A refused byte must still close its slot, so the slot is counted.
                        bit_cnt <= 4'h1;
                        SDA_OE_OUT <= ack_ok;
                        SDA_OUT <= 1'b0;
                    end else if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        SDA_OE_OUT <= 1'b0;
                        if (!ack_ok) begin
                            state <= ST_IDLE;
                        end else if (rd_mode) begin
                            state <= ST_TX;
                            shreg <= cur_w[7:0];
                            SDA_OE_OUT <= !cur_w[7];
                            SDA_OUT <= 1'b0;
                        end else begin
                            state <= ret_state;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        shreg <= {shreg[6:0], 1'b1};
                        if (bit_cnt == `I2CREC_BITS_PER_BYTE - 4'h1) begin
                            bit_cnt <= 4'h0;
                            SDA_OE_OUT <= 1'b0;
                            state <= ST_RXACK;
                        end else begin
                            SDA_OE_OUT <= !shreg[6];
                        end
                    end
                end
                ST_RXACK: begin
                    if (scl_rise) begin
                        // A released acknowledge slot ends the read.
                        state <= SDA_IN ? ST_IDLE : ST_RXACK;
                    end else if (scl_fall) begin
                        state <= ST_TX;
                        shreg <= cur_w[7:0];
                        SDA_OE_OUT <= !cur_w[7];
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Wipers sit outside the engine so recovery never disturbs them.
    logic [8:0] next_wiper [`I2CREC_NUM_WIPERS];
    wire commit = stop_det && wr_pend && (opc == `I2CREC_CMD_WRITE);
    always_comb begin
        for (int i = 0; i < `I2CREC_NUM_WIPERS; i++) begin
            next_wiper[i] = wiper[i];
        end
        if (do_inc) begin
            next_wiper[widx] = cur_w + 9'h001;
        end else if (do_dec) begin
            next_wiper[widx] = cur_w - 9'h001;
        end else if (commit) begin
            next_wiper[widx] = wr_val;
        end
    end
    always_ff @(posedge CLK_SYS_IN or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `I2CREC_NUM_WIPERS; i++) begin
                wiper[i] <= `I2CREC_WIPER_MID;
            end
            WIPER0_OUT <= `I2CREC_WIPER_MID;
            WIPER1_OUT <= `I2CREC_WIPER_MID;
            WIPER2_OUT <= `I2CREC_WIPER_MID;
            WIPER3_OUT <= `I2CREC_WIPER_MID;
            BUSY_OUT <= 1'b0;
        end else begin
            wiper <= next_wiper;
            WIPER0_OUT <= next_wiper[0];
            WIPER1_OUT <= next_wiper[1];
            WIPER2_OUT <= next_wiper[2];
            WIPER3_OUT <= next_wiper[3];
            BUSY_OUT <= (state != ST_IDLE);
        end
    end

    stop_idle_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rstn)
        stop_det && !start_seen |=> state == ST_IDLE)
        else $error("Stop did not return engine to idle.");
    start_reset_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rstn)
        start_seen |=> state == ST_ADDR && bit_cnt == 4'h0)
        else $error("Start did not restart engine.");
    held_blind_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rstn)
        line_held && !stop_det |=> state != ST_ADDR)
        else $error("Start seen while holding line low.");
    nack_end_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rstn)
        state == ST_RXACK && scl_rise && SDA_IN && !start_seen && !stop_det
        |=> state == ST_IDLE)
        else $error("Released acknowledge did not end read.");
    recovery_keep_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rstn)
        (start_seen || stop_det) && !commit |=> $stable({wiper[0], wiper[1], wiper[2], wiper[3]}))
        else $error("Recovery changed a wiper.");
    inc_step_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rstn)
        do_inc |=> wiper[$past(widx)] == $past(cur_w) + 9'h001)
        else $error("Increment did not step by one.");
    dec_step_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rstn)
        do_dec |=> wiper[$past(widx)] == $past(cur_w) - 9'h001)
        else $error("Decrement did not step by one.");
    gencall_ack_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rstn)
        state == ST_ADDR && byte_done && gc_hit && !start_seen && !stop_det
        |=> ack_ok && gencall)
        else $error("General call not accepted.");
    restart_cancel_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rstn)
        start_seen |=> !wr_pend)
        else $error("Second Start left write armed.");
    write_commit_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rstn)
        commit && !do_inc && !do_dec |=> wiper[$past(widx)] == $past(wr_val))
        else $error("Armed write not committed on Stop.");
    gencall_c: cover property (@(posedge CLK_SYS_IN) gencall && do_inc);
    nack_c: cover property (@(posedge CLK_SYS_IN) state == ST_RXACK && scl_rise && SDA_IN);
    blind_c: cover property (@(posedge CLK_SYS_IN) line_held && state == ST_TX && scl_rise);
    commit_c: cover property (@(posedge CLK_SYS_IN) commit);
endmodule

// ===== sim/i2crec_master.sv
// Purpose: Behavioural bus master that drives SCL and SDA for the serial engine bench.
// Assumes: SDA is open drain; the bench resolves it with a pull-up.
// Notes: Lines change only just after a rising clock edge.
`timescale 1ns/100ps
module i2crec_master #(
    parameter int QTR = 4
) (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic drive(input logic c, input logic d);
        @(posedge clk_in);
        scl_out <= c;
        sda_out <= d;
        repeat (QTR - 1) @(posedge clk_in);
    endtask
    // Data only moves while SCL is low, so Start and Stop are the only SDA edges seen with SCL high.
    task automatic start();
        drive(scl_out, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        drive(1'b0, 1'b0);
    endtask
    task automatic stop();
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
    endtask
    task automatic send_bit(input logic b, output logic r);
        drive(1'b0, b);
        drive(1'b1, b);
        r = sda_in;
        drive(1'b0, b);
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i], r);
        end
        send_bit(1'b1, ack);
    endtask
    task automatic rd_byte(input logic ack_lvl, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            send_bit(1'b1, d[i]);
        end
        send_bit(ack_lvl, r);
    endtask
    task automatic recover();
        logic r;
        start();
        repeat (9) send_bit(1'b1, r);
        start();
        stop();
    endtask
endmodule

// ===== sim/tb.sv
// Purpose: Self-checking bench for the serial engine with bus recovery.
// Assumes: The master model drives the bus; SDA has a pull-up.
// Notes: Wiper values are tracked by hand across the scenarios.
`timescale 1ns/100ps
`include "i2crec_params.svh"
module tb;
    localparam logic [7:0] DW = {`I2CREC_DEV_ADDR, 1'b0};
    localparam logic [7:0] DR = {`I2CREC_DEV_ADDR, 1'b1};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic scl, m_sda, oe, sdo, busy, ack;
    logic [8:0] w [4];
    logic [7:0] d;
    int errors = 0;
    int n_compared = 0;
    wire logic sda = m_sda & ~(oe & ~sdo);
    i2crec_top u_i2crec_top (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sdo), .SDA_OE_OUT(oe), .WIPER0_OUT(w[0]), .WIPER1_OUT(w[1]),
        .WIPER2_OUT(w[2]), .WIPER3_OUT(w[3]), .BUSY_OUT(busy));
    i2crec_master u_i2crec_master (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic test_done();
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wipers(input logic [8:0] a, input logic [8:0] b, input logic [8:0] c,
                          input logic [8:0] e);
        chk("wiper0", a, w[0]);
        chk("wiper1", b, w[1]);
        chk("wiper2", c, w[2]);
        chk("wiper3", e, w[3]);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk);
        chk("busy", 9'h000, {8'h00, busy});
    endtask
    function automatic logic [7:0] cmd(input logic [1:0] wi, input logic [1:0] op);
        return {4'h0, wi, op};
    endfunction
    task automatic frame(input logic [7:0] a, input logic [7:0] c);
        u_i2crec_master.start();
        u_i2crec_master.wr_byte(a, ack);
        chk("addr ack", 9'h000, {8'h00, ack});
        u_i2crec_master.wr_byte(c, ack);
        chk("cmd ack", 9'h000, {8'h00, ack});
    endtask
    task automatic t_step();
        frame(DW, cmd(2'h1, `I2CREC_CMD_INC));
        chk("wiper1", 9'h081, w[1]);
        u_i2crec_master.stop();
        frame(DW, cmd(2'h1, `I2CREC_CMD_DEC));
        chk("wiper1", 9'h080, w[1]);
        u_i2crec_master.stop();
    endtask
    task automatic t_gencall();
        frame(8'h00, cmd(2'h2, `I2CREC_CMD_INC));
        chk("wiper2", 9'h081, w[2]);
        u_i2crec_master.stop();
        frame(8'h00, cmd(2'h3, `I2CREC_CMD_WRITE));
        u_i2crec_master.wr_byte(8'h55, ack);
        u_i2crec_master.stop();
        chk("wiper3", 9'h055, w[3]);
        frame(8'h00, cmd(2'h3, `I2CREC_CMD_WRITE));
        u_i2crec_master.wr_byte(8'h00, ack);
        u_i2crec_master.stop();
        frame(8'h00, cmd(2'h3, `I2CREC_CMD_DEC));
        u_i2crec_master.stop();
        chk("wiper3", 9'h000, w[3]);
        u_i2crec_master.start();
        u_i2crec_master.wr_byte(8'h01, ack);
        chk("gc read ack", 9'h001, {8'h00, ack});
        u_i2crec_master.stop();
    endtask
    task automatic t_rec_write();
        frame(DW, cmd(2'h0, `I2CREC_CMD_WRITE));
        repeat (4) u_i2crec_master.send_bit(1'b0, ack);
        u_i2crec_master.recover();
        wait_idle();
        wipers(9'h080, 9'h080, 9'h081, 9'h000);
    endtask
    task automatic t_held_ack();
        u_i2crec_master.start();
        for (int i = 7; i >= 0; i--) u_i2crec_master.send_bit(DW[i], ack);
        u_i2crec_master.drive(1'b0, 1'b1);
        u_i2crec_master.drive(1'b1, 1'b1);
        u_i2crec_master.drive(1'b1, 1'b0);
        chk("oe", 9'h001, {8'h00, oe});
        chk("busy", 9'h001, {8'h00, busy});
        u_i2crec_master.drive(1'b0, 1'b0);
        u_i2crec_master.recover();
        wait_idle();
        wipers(9'h080, 9'h080, 9'h081, 9'h000);
    endtask
    task automatic t_read_nack();
        u_i2crec_master.start();
        u_i2crec_master.wr_byte(DR, ack);
        chk("read ack", 9'h000, {8'h00, ack});
        u_i2crec_master.rd_byte(1'b1, d);
        chk("read data", 9'h080, {1'b0, d});
        chk("oe", 9'h000, {8'h00, oe});
        wait_idle();
        u_i2crec_master.stop();
        frame(DW, cmd(2'h0, `I2CREC_CMD_INC));
        u_i2crec_master.stop();
        chk("wiper0", 9'h081, w[0]);
    endtask
    task automatic t_rec_read();
        logic r;
        u_i2crec_master.start();
        u_i2crec_master.wr_byte(DR, ack);
        chk("read ack", 9'h000, {8'h00, ack});
        u_i2crec_master.send_bit(1'b1, r);
        chk("read bit7", 9'h001, {8'h00, r});
        chk("oe", 9'h001, {8'h00, oe});
        u_i2crec_master.recover();
        wait_idle();
        wipers(9'h081, 9'h080, 9'h081, 9'h000);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        wipers(9'h080, 9'h080, 9'h080, 9'h080);
        chk("oe", 9'h000, {8'h00, oe});
        t_step();
        t_gencall();
        t_rec_write();
        t_held_ack();
        t_read_nack();
        t_rec_read();
        test_done();
    end
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        $display("[ERR] run expected done seen hang");
        test_done();
    end
endmodule
